//--- src/bccp_top.sv
// Top of the bus clock calendar port: I/O port pair, control register, time and power gate.
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`include "bccp_defines.svh"
module bccp_top import bccp_pkg::*; #(
  parameter int unsigned QUAL_CYC = `BCCP_QUAL_CYC,
  parameter int unsigned SETTLE_CYC = `BCCP_SETTLE_CYC,
  parameter int unsigned TICK16_CYC = `BCCP_TICK16_CYC
) (
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // Bus cycle and address straps
  input wire bccp_io_s i_io,
  input wire logic [6:0] i_strap_fitted,
  // Data bus drive
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Supply monitor
  input wire logic i_supply_fail_detect,
  input wire logic i_supply_recovered,
  output logic o_access_enabled,
  // Interval ticks toward the external counter timer
  output bccp_tick_s o_ticks
);
  localparam int CW = $clog2(SETTLE_CYC + QUAL_CYC + 1);

  // ****************************************************************
  // Interval ticks
  // ****************************************************************
  logic tick16, tick1;

  bccp_prescaler #(
    .DIV16(TICK16_CYC),
    .PER_SEC(`BCCP_TICKS_PER_SEC)
  ) u_prescaler (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_clk_en(i_clk_en),
    .o_tick16(tick16),
    .o_tick1(tick1)
  );

  // ****************************************************************
  // Power gate
  // ****************************************************************
  bccp_pwr_e pwr_reg, pwr_next;
  logic [CW-1:0] pwr_cnt_reg, pwr_cnt_next;

  always_comb begin
    pwr_next = pwr_reg;
    pwr_cnt_next = pwr_cnt_reg;
    unique case (pwr_reg)
      BCCP_ON: begin
        if (!i_supply_fail_detect) begin
          pwr_cnt_next = '0;
        end else if (pwr_cnt_reg == CW'(QUAL_CYC)) begin
          pwr_next = BCCP_OFF;
          pwr_cnt_next = '0;
        end else begin
          pwr_cnt_next = pwr_cnt_reg + CW'(1);
        end
      end
      BCCP_OFF: begin
        if (i_supply_recovered && !i_supply_fail_detect) begin
          pwr_next = BCCP_SETTLE;
          pwr_cnt_next = '0;
        end
      end
      BCCP_SETTLE: begin
        // A new dip during settling restarts the whole recovery.
        if (i_supply_fail_detect) begin
          pwr_next = BCCP_OFF;
          pwr_cnt_next = '0;
        end else if (pwr_cnt_reg == CW'(SETTLE_CYC - 1)) begin
          pwr_next = BCCP_ON;
          pwr_cnt_next = '0;
        end else begin
          pwr_cnt_next = pwr_cnt_reg + CW'(1);
        end
      end
      default: begin
        pwr_next = BCCP_OFF;
        pwr_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwr_reg <= BCCP_ON;
      pwr_cnt_reg <= '0;
    end else if (i_clk_en) begin
      pwr_reg <= pwr_next;
      pwr_cnt_reg <= pwr_cnt_next;
    end
  end

  // ****************************************************************
  // Port decode and control register
  // ****************************************************************
  bccp_ctrl_s ctrl_reg, ctrl_next;
  logic pair_reg, pair_next;
  logic hit, wr_ctrl, wr_odd, rd_even, rd_odd, adv;
  logic clk_clear, cal_clear, sec_set, min_set, day_set;

  // Locked-out cycles fall through here, so counters never see them.
  assign hit = (i_io.addr[7:1] == ~i_strap_fitted) && (pwr_reg == BCCP_ON);
  assign wr_ctrl = hit && i_io.wr && (i_io.addr[0] == `BCCP_PORT_EVEN);
  assign wr_odd = hit && i_io.wr && (i_io.addr[0] == `BCCP_PORT_ODD);
  assign rd_even = hit && i_io.rd && (i_io.addr[0] == `BCCP_PORT_EVEN);
  assign rd_odd = hit && i_io.rd && (i_io.addr[0] == `BCCP_PORT_ODD);
  assign adv = wr_odd && pair_reg;
  assign clk_clear = wr_ctrl && i_io.wdata[`BCCP_BIT_CLK_RST] && !ctrl_reg.clk_reset;
  assign cal_clear = wr_ctrl && i_io.wdata[`BCCP_BIT_CAL_RST] && !ctrl_reg.cal_reset;
  // Selection priority follows the read mux, so hours swallow the pulse.
  assign sec_set = adv && ctrl_reg.sec_sel;
  assign min_set = adv && !ctrl_reg.sec_sel && ctrl_reg.min_sel;
  assign day_set = adv && !ctrl_reg.sec_sel && !ctrl_reg.min_sel && !ctrl_reg.hour_sel
                   && ctrl_reg.cal_sel;

  always_comb begin
    ctrl_next = ctrl_reg;
    pair_next = pair_reg;
    if (wr_ctrl) begin
      ctrl_next = bccp_ctrl_s'(i_io.wdata);
      pair_next = 1'b0;
    end else if (wr_odd) begin
      pair_next = !pair_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= bccp_ctrl_s'(`BCCP_CTRL_RESET);
      pair_reg <= 1'b0;
    end else if (i_clk_en) begin
      ctrl_reg <= ctrl_next;
      pair_reg <= pair_next;
    end
  end

  // ****************************************************************
  // Time counters
  // ****************************************************************
  bccp_time_s time_reg, time_next;
  logic tick_sec, sec_inc, sec_wrap, min_inc, min_wrap, hour_wrap;

  // A set pulse landing on a tick adds only one second; software rereads anyway.
  assign tick_sec = tick1 && !ctrl_reg.clk_reset;
  assign sec_inc = tick_sec || sec_set;
  assign sec_wrap = sec_inc && (time_reg.sec == `BCCP_SEC_LAST);
  assign min_inc = sec_wrap || min_set;
  assign min_wrap = min_inc && (time_reg.min == `BCCP_MIN_LAST);
  assign hour_wrap = min_wrap && (time_reg.hour == `BCCP_HOUR_LAST);

  always_comb begin
    time_next = time_reg;
    if (clk_clear) begin
      time_next = '{hour: `BCCP_ZERO, min: `BCCP_ZERO, sec: `BCCP_ZERO};
    end else begin
      if (sec_inc) begin
        time_next.sec = sec_wrap ? `BCCP_ZERO : bccp_bcd_inc(time_reg.sec);
      end
      if (min_inc) begin
        time_next.min = min_wrap ? `BCCP_ZERO : bccp_bcd_inc(time_reg.min);
      end
      if (min_wrap) begin
        time_next.hour = hour_wrap ? `BCCP_ZERO : bccp_bcd_inc(time_reg.hour);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      time_reg <= '{hour: `BCCP_ZERO, min: `BCCP_ZERO, sec: `BCCP_ZERO};
    end else if (i_clk_en) begin
      time_reg <= time_next;
    end
  end

  // ****************************************************************
  // Calendar
  // ****************************************************************
  logic [7:0] month, day;

  bccp_calendar u_calendar (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_clk_en(i_clk_en),
    .i_reset(cal_clear),
    .i_advance(hour_wrap || day_set),
    .i_leap(ctrl_reg.leap),
    .o_month(month),
    .o_day(day)
  );

  // ****************************************************************
  // Read data and outputs
  // ****************************************************************
  logic [7:0] sel_data, data_next;
  logic oe_next;
  bccp_tick_s ticks_next;

  always_comb begin
    if (ctrl_reg.sec_sel) begin
      sel_data = time_reg.sec;
    end else if (ctrl_reg.min_sel) begin
      sel_data = time_reg.min;
    end else if (ctrl_reg.hour_sel) begin
      sel_data = time_reg.hour;
    end else if (ctrl_reg.cal_sel) begin
      sel_data = ctrl_reg.day_sel ? day : month;
    end else begin
      sel_data = `BCCP_IDLE_DATA;
    end
    // Odd reads drive a fixed filler byte and touch no state.
    data_next = `BCCP_IDLE_DATA;
    oe_next = rd_even || rd_odd;
    if (rd_even) begin
      data_next = sel_data;
    end
    ticks_next = '{hour: min_wrap, min: sec_wrap, sec: tick_sec, t16: tick16};
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= `BCCP_IDLE_DATA;
      o_data_oe <= 1'b0;
      o_access_enabled <= 1'b1;
      o_ticks <= '0;
    end else if (i_clk_en) begin
      o_data <= data_next;
      o_data_oe <= oe_next;
      o_access_enabled <= (pwr_next == BCCP_ON);
      o_ticks <= ticks_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ctrl_load;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && wr_ctrl) |=> (ctrl_reg == bccp_ctrl_s'($past(i_io.wdata)));
  endproperty
  a_ctrl_load: assert property (p_ctrl_load)
    else $error("Control register did not take the written byte.");

  property p_sec_read;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && rd_even && ctrl_reg.sec_sel) |=> (o_data_oe && o_data == $past(time_reg.sec));
  endproperty
  a_sec_read: assert property (p_sec_read)
    else $error("Even port read did not return seconds.");

  property p_odd_read_quiet;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && rd_odd && !i_io.wr) |=> ($stable(ctrl_reg) && $stable(pair_reg));
  endproperty
  a_odd_read_quiet: assert property (p_odd_read_quiet)
    else $error("Odd port read changed state.");

  property p_pair_second;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && wr_odd && !pair_reg) |=> pair_reg;
  endproperty
  a_pair_second: assert property (p_pair_second)
    else $error("Pair tracker did not arm on the first odd write.");

  property p_clock_clear;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && clk_clear) |=> (time_reg == '0);
  endproperty
  a_clock_clear: assert property (p_clock_clear)
    else $error("Rising bit 0 did not clear the time.");

  property p_pause;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && ctrl_reg.clk_reset && !sec_set) |=> (time_reg.sec == $past(time_reg.sec));
  endproperty
  a_pause: assert property (p_pause)
    else $error("Seconds moved while the clock was held.");

  property p_lockout;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (pwr_reg != BCCP_ON) |=> $stable(ctrl_reg);
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("Control register changed during lockout.");

  property p_settle;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(pwr_reg == BCCP_ON) |-> ($past(pwr_reg) == BCCP_SETTLE
                                   && $past(pwr_cnt_reg) == CW'(SETTLE_CYC - 1));
  endproperty
  a_settle: assert property (p_settle)
    else $error("Access returned before the settling delay.");

  property p_hour_carry;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && min_wrap && !clk_clear && time_reg.hour == 8'h09) |=> (time_reg.hour == 8'h10);
  endproperty
  a_hour_carry: assert property (p_hour_carry)
    else $error("Minute wrap did not advance hours.");

  property p_hour_wrap;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && hour_wrap && !clk_clear) |=> (time_reg.hour == `BCCP_ZERO);
  endproperty
  a_hour_wrap: assert property (p_hour_wrap)
    else $error("Hours did not wrap after 23.");
endmodule

//--- common/bccp_defines.svh
// Constants of the bus clock calendar port: offsets, fields, limits and timing counts.
`ifndef BCCP_DEFINES_SVH
`define BCCP_DEFINES_SVH

// ****************************************************************
// Port selection and control register
// ****************************************************************
`define BCCP_PORT_EVEN 1'b0
`define BCCP_PORT_ODD 1'b1
`define BCCP_CTRL_RESET 8'h00
`define BCCP_BIT_CLK_RST 0
`define BCCP_BIT_CAL_RST 1
`define BCCP_IDLE_DATA 8'h00

// ****************************************************************
// Counter limits in BCD, except the binary end of year hold limit
// ****************************************************************
`define BCCP_SEC_LAST 8'h59
`define BCCP_MIN_LAST 8'h59
`define BCCP_HOUR_LAST 8'h23
`define BCCP_ZERO 8'h00
`define BCCP_FIRST_DAY 8'h01
`define BCCP_FIRST_MONTH 8'h01
`define BCCP_FEB 8'h02
`define BCCP_LAST_MONTH 8'h12
`define BCCP_EOY_MONTH 8'h81
`define BCCP_EOY_LIMIT 8'hFF

// ****************************************************************
// Timing
// ****************************************************************
`define BCCP_CLK_NS 100
`define BCCP_QUAL_NS 9000
`define BCCP_QUAL_CYC ((`BCCP_QUAL_NS + `BCCP_CLK_NS - 1) / `BCCP_CLK_NS)
`define BCCP_SETTLE_MS 5
`define BCCP_SETTLE_CYC ((`BCCP_SETTLE_MS * 1000000 + `BCCP_CLK_NS - 1) / `BCCP_CLK_NS)
`define BCCP_TICK16_NS 62500000
`define BCCP_TICK16_CYC (`BCCP_TICK16_NS / `BCCP_CLK_NS)
`define BCCP_TICKS_PER_SEC 16

`endif

//--- common/bccp_pkg.sv
// Types and shared arithmetic of the bus clock calendar port.
package bccp_pkg;

  // Control register, bit 7 down to bit 0.
  typedef struct packed {
    logic leap;
    logic day_sel;
    logic cal_sel;
    logic hour_sel;
    logic min_sel;
    logic sec_sel;
    logic cal_reset;
    logic clk_reset;
  } bccp_ctrl_s;

  // One bus cycle as seen on the port pins.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bccp_io_s;

  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } bccp_time_s;

  typedef struct packed {
    logic hour;
    logic min;
    logic sec;
    logic t16;
  } bccp_tick_s;

  typedef enum logic [1:0] {
    BCCP_ON = 2'b00,
    BCCP_OFF = 2'b01,
    BCCP_SETTLE = 2'b11
  } bccp_pwr_e;

  // Adds one to a two-digit BCD value; the caller handles the wrap.
  function automatic logic [7:0] bccp_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

endpackage

//--- src/bccp_prescaler.sv
// Divider from the core clock to the sixteen per second and once per second ticks.
`timescale 1ns/1ps
`include "bccp_defines.svh"
module bccp_prescaler import bccp_pkg::*; #(
  parameter int unsigned DIV16 = `BCCP_TICK16_CYC,
  parameter int unsigned PER_SEC = `BCCP_TICKS_PER_SEC
) (
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // Tick pulses
  output logic o_tick16,
  output logic o_tick1
);
  localparam int W = (DIV16 > 1) ? $clog2(DIV16) : 1;
  localparam int SW = (PER_SEC > 1) ? $clog2(PER_SEC) : 1;

  logic [W-1:0] div_reg, div_next;
  logic [SW-1:0] sub_reg, sub_next;
  logic t16_next, t1_next;

  always_comb begin
    div_next = div_reg;
    sub_next = sub_reg;
    t16_next = 1'b0;
    t1_next = 1'b0;
    if (div_reg == W'(DIV16 - 1)) begin
      div_next = '0;
      t16_next = 1'b1;
      if (sub_reg == SW'(PER_SEC - 1)) begin
        sub_next = '0;
        t1_next = 1'b1;
      end else begin
        sub_next = sub_reg + SW'(1);
      end
    end else begin
      div_next = div_reg + W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_reg <= '0;
      sub_reg <= '0;
      o_tick16 <= 1'b0;
      o_tick1 <= 1'b0;
    end else if (i_clk_en) begin
      div_reg <= div_next;
      sub_reg <= sub_next;
      o_tick16 <= t16_next;
      o_tick1 <= t1_next;
    end
  end

  property p_tick1_on_tick16;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    o_tick1 |-> o_tick16;
  endproperty
  a_tick1_on_tick16: assert property (p_tick1_on_tick16)
    else $error("Once per second tick without a sixteenth tick.");
endmodule

//--- src/bccp_calendar.sv
// Month and day counters with leap selection and the end of year overflow.
`timescale 1ns/1ps
`include "bccp_defines.svh"
module bccp_calendar import bccp_pkg::*; (
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // Control
  input wire logic i_reset,
  input wire logic i_advance,
  input wire logic i_leap,
  // Calendar state
  output logic [7:0] o_month,
  output logic [7:0] o_day
);
  logic [7:0] month_next, day_next;

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic leap);
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  always_comb begin
    month_next = o_month;
    day_next = o_day;
    if (i_reset) begin
      month_next = `BCCP_FIRST_MONTH;
      day_next = `BCCP_FIRST_DAY;
    end else if (i_advance) begin
      if (o_month[7]) begin
        // Past year end the month counts days in binary, holding at FF, until software resets it.
        if (o_month != `BCCP_EOY_LIMIT) begin
          month_next = o_month + 8'h01;
        end
      end else if (o_day == last_day(o_month, i_leap)) begin
        day_next = `BCCP_FIRST_DAY;
        if (o_month == `BCCP_LAST_MONTH) begin
          month_next = `BCCP_EOY_MONTH;
        end else begin
          month_next = bccp_bcd_inc(o_month);
        end
      end else begin
        day_next = bccp_bcd_inc(o_day);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_month <= `BCCP_FIRST_MONTH;
      o_day <= `BCCP_FIRST_DAY;
    end else if (i_clk_en) begin
      o_month <= month_next;
      o_day <= day_next;
    end
  end

  property p_year_end;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && i_advance && !i_reset && o_month == `BCCP_LAST_MONTH && o_day == 8'h31)
      |=> (o_month == `BCCP_EOY_MONTH);
  endproperty
  a_year_end: assert property (p_year_end)
    else $error("Month did not enter the end of year value.");

  property p_leap_feb;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && i_advance && !i_reset && o_month == `BCCP_FEB && o_day == 8'h28)
      |=> (o_day == (i_leap ? 8'h29 : `BCCP_FIRST_DAY));
  endproperty
  a_leap_feb: assert property (p_leap_feb)
    else $error("February end does not follow the leap selection.");
endmodule

//--- tb/bccp_host_model.sv
// Host processor model issuing I/O cycles on the clock port pair.
`timescale 1ns/1ps
module bccp_host_model import bccp_pkg::*; (
  // Clock and read answer
  input wire logic i_core_clk,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  // Bus cycle
  output bccp_io_s o_io
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  initial begin
    o_io = '0;
  end

  // Released lines show inverted values so a stale address or byte is never taken as valid.
  task automatic cyc(input logic rd, input logic [7:0] addr, input logic [7:0] wd);
    @(negedge i_core_clk);
    o_io = {rd, ~rd, addr, wd};
    @(negedge i_core_clk);
    o_io = {2'b00, ~addr, ~wd};
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] d, output logic ok);
    cyc(1'b1, addr, 8'h00);
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 3 && !ok; n++) begin
      if (i_data_oe === 1'b1) begin
        ok = 1'b1;
        d = i_data;
      end else begin
        @(negedge i_core_clk);
      end
    end
  endtask

  task automatic pair(input logic [7:0] base);
    cyc(1'b0, base | 8'h01, 8'h00);
    cyc(1'b0, base | 8'h01, 8'h00);
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the bus clock calendar port.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top import bccp_pkg::*;;
  // ****************************************************************
  // Bench signals and instances
  // ****************************************************************
  localparam logic [7:0] BASE = 8'h70;
  logic clk, arst_n, en, fail, rec, acc, oe, ok;
  logic [6:0] strap;
  logic [7:0] data, got;
  bccp_io_s io;
  bccp_tick_s ticks;
  int checks = 0;
  int fail_count = 0;
  int n16 = 0;
  int nsec = 0;
  int nhr = 0;
  int a16, asec;

  bccp_top #(.QUAL_CYC(3), .SETTLE_CYC(8), .TICK16_CYC(4)) i_dut (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_clk_en(en), .i_io(io),
    .i_strap_fitted(strap), .o_data(data), .o_data_oe(oe),
    .i_supply_fail_detect(fail), .i_supply_recovered(rec),
    .o_access_enabled(acc), .o_ticks(ticks));
  bccp_host_model i_host (.i_core_clk(clk), .i_data(data), .i_data_oe(oe), .o_io(io));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Ticks are counted on the falling edge, where the registered pulses have settled.
  always @(negedge clk) begin
    n16 += int'(ticks.t16);
    nsec += int'(ticks.sec);
    nhr += int'(ticks.hour);
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.cyc(1'b0, a, d);
  endtask
  task automatic rchk(input string n, input logic [7:0] exp);
    i_host.rd(BASE, got, ok);
    `CHK(n, 1'b1, ok)
    `CHK(n, exp, got)
  endtask
  // A stuck supply state would hang the run, so every wait is capped.
  task automatic wait_acc(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && acc !== v; n++) @(negedge clk);
    if (acc !== v) begin
      $display("MISMATCH access exp %h got %h", v, acc);
      fail_count++;
      tally_and_finish();
    end
  endtask

  initial begin
    #2ms;
    $display("MISMATCH run time exp %h got %h", 1'b0, 1'b1);
    fail_count++;
    tally_and_finish();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    en = 1'b1;
    fail = 1'b0;
    rec = 1'b0;
    strap = 7'h47;
    repeat (5) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    rchk("no select", 8'h00);
    `CHK("access", 1'b1, acc)
    wr(BASE, 8'h05);
    rchk("sec reset", 8'h00);
    i_host.pair(BASE);
    rchk("sec set", 8'h01);
    i_host.cyc(1'b0, BASE | 8'h01, 8'h00);
    wr(BASE, 8'h05);
    i_host.cyc(1'b0, BASE | 8'h01, 8'h00);
    rchk("pair cleared", 8'h01);
    i_host.rd(BASE | 8'h01, got, ok);
    `CHK("odd read", 8'h00, got)
    rchk("odd no effect", 8'h01);
    wr(8'h72, 8'h00);
    rchk("strap miss", 8'h01);
    $display("END port access");
    wr(BASE, 8'h09);
    repeat (59) i_host.pair(BASE);
    rchk("min 59", 8'h59);
    i_host.pair(BASE);
    rchk("min wrap", 8'h00);
    wr(BASE, 8'h11);
    rchk("hour carry", 8'h01);
    i_host.pair(BASE);
    rchk("hour no set", 8'h01);
    wr(BASE, 8'h09);
    repeat (1379) i_host.pair(BASE);
    wr(BASE, 8'h11);
    rchk("hour 23", 8'h23);
    wr(BASE, 8'h09);
    i_host.pair(BASE);
    wr(BASE, 8'h11);
    rchk("hour wrap", 8'h00);
    `CHK("hour ticks", 24, nhr)
    wr(BASE, 8'h61);
    rchk("day carry", 8'h02);
    wr(BASE, 8'h04);
    wr(BASE, 8'h05);
    rchk("clock clear", 8'h00);
    wr(BASE, 8'h05);
    repeat (200) @(negedge clk);
    rchk("frozen", 8'h00);
    wr(BASE, 8'h04);
    a16 = n16;
    asec = nsec;
    repeat (128) @(negedge clk);
    `CHK("tick16", 32, n16 - a16)
    `CHK("tick1", 2, nsec - asec)
    $display("END time counters");
    wr(BASE, 8'h02);
    wr(BASE, 8'h20);
    rchk("month", 8'h01);
    wr(BASE, 8'h60);
    rchk("day", 8'h01);
    i_host.pair(BASE);
    rchk("day set", 8'h02);
    wr(BASE, 8'hE0);
    repeat (57) i_host.pair(BASE);
    rchk("feb 28", 8'h28);
    i_host.pair(BASE);
    rchk("leap day", 8'h29);
    wr(BASE, 8'hA0);
    rchk("feb", 8'h02);
    repeat (306) i_host.pair(BASE);
    rchk("dec", 8'h12);
    i_host.pair(BASE);
    rchk("year end", 8'h81);
    i_host.pair(BASE);
    rchk("binary days", 8'h82);
    $display("END calendar");
    @(negedge clk) fail = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("qualify", 1'b1, acc)
    wait_acc(1'b0, 3);
    a16 = n16;
    i_host.rd(BASE, got, ok);
    `CHK("locked read", 1'b0, ok)
    `CHK("ticks run", 1'b1, n16 > a16)
    wr(BASE, 8'h04);
    fail = 1'b0;
    rec = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("settling", 1'b0, acc)
    wait_acc(1'b1, 12);
    rec = 1'b0;
    rchk("after recovery", 8'h82);
    $display("END power gate");
    tally_and_finish();
  end
endmodule
